// ---- design/cdfa_core.sv ----
`timescale 1ns/10ps
`include "cdfa_regs.svh"
module cdfa_core (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic [5:0]  op_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [2:0]  rd_in,
  input  wire logic [2:0]  rs_in,
  input  wire logic [31:0] imm_in,
  input  wire logic        use_imm_in,
  input  wire logic        hi_byte_in,
  input  wire logic [2:0]  bit_in,
  input  wire logic [23:0] fetch_pc_in,
  input  wire logic [31:0] mem_rdata_in,
  input  wire logic        mem_ack_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             illegal_out,
  output logic [2:0]       group_out,
  output logic [23:0]      fetch_addr_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [1:0]       mem_size_out,
  output logic [23:0]      mem_addr_out,
  output logic [31:0]      mem_wdata_out,
  output logic [7:0]       ccr_out,
  output logic [31:0]      rd_value_out
);
  logic [31:0]           gr_reg [0:7];
  logic [7:0]            ccr_reg;
  cdfa_pkg::cdfa_state_t st_reg;
  logic [2:0]            dst_reg;
  logic [1:0]            sz_reg;
  logic                  ld_reg;
  logic [31:0]           prod;
  logic [31:0]           src;
  logic [31:0]           dst;
  logic [31:0]           res;
  logic [7:0]            ccr_next;
  logic                  wr_en;
  logic                  bad;
  logic [31:0]           sp_val;

  // mask a value to the operand size
  function automatic logic [31:0] fit(input logic [31:0] v,
                                      input logic [1:0] sz);
    unique case (sz)
      `CDFA_SZ_BYTE: fit = {24'h000000, v[7:0]};
      `CDFA_SZ_WORD: fit = {16'h0000, v[15:0]};
      default:       fit = v;
    endcase
  endfunction : fit

  // sign bit of a value at a size
  function automatic logic msb(input logic [31:0] v, input logic [1:0] sz);
    unique case (sz)
      `CDFA_SZ_BYTE: msb = v[7];
      `CDFA_SZ_WORD: msb = v[15];
      default:       msb = v[31];
    endcase
  endfunction : msb

  // byte access picks the high or low byte of the 16-bit half
  function automatic logic [31:0] rd_op(input logic [31:0] r,
                                        input logic [1:0] sz,
                                        input logic hi);
    if (sz == `CDFA_SZ_BYTE)
      rd_op = {24'h000000, hi ? r[15:8] : r[7:0]};
    else
      rd_op = fit(r, sz);
  endfunction : rd_op

  function automatic cdfa_pkg::cdfa_group_t grp(input logic [5:0] op);
    if (op <= `CDFA_OP_PSYNC_ST)
      grp = cdfa_pkg::CDFA_GRP_XFER;
    else if (op >= `CDFA_OP_BITSET)
      grp = cdfa_pkg::CDFA_GRP_BIT;
    else
      grp = cdfa_pkg::CDFA_GRP_ARITH;
  endfunction : grp

  cdfa_mul u_mul (
    .a_in      (dst[15:0]),
    .b_in      (src[15:0]),
    .word_in   (size_in != `CDFA_SZ_BYTE),
    .signed_in (op_in == `CDFA_OP_MULS),
    .prod_out  (prod)
  );

  assign sp_val = gr_reg[`CDFA_SP_IDX];

  always_comb begin
    logic [32:0] sum;
    logic        hc;
    logic        cin;
    logic [3:0]  lo;
    logic [3:0]  hi;
    logic [7:0]  adj;
    logic        sub;
    logic [31:0] a;
    logic [31:0] b;
    logic        c0;
    sum = 33'h0;
    sub = 1'b0;
    a = 32'h0;
    b = 32'h0;
    c0 = 1'b0;
    hc = 1'b0;
    cin = ccr_reg[`CDFA_CC_C];
    lo = 4'h0;
    hi = 4'h0;
    adj = 8'h00;
    src = use_imm_in ? fit(imm_in, size_in)
                     : rd_op(gr_reg[rs_in], size_in, hi_byte_in);
    dst = rd_op(gr_reg[rd_in], size_in, hi_byte_in);
    res = dst;
    ccr_next = ccr_reg;
    wr_en = 1'b0;
    bad = 1'b0;
    unique case (op_in)
      `CDFA_OP_MOV_RR, `CDFA_OP_MOV_IMM: begin
        res = src;
        wr_en = 1'b1;
        ccr_next[`CDFA_CC_N] = msb(src, size_in);
        ccr_next[`CDFA_CC_Z] = (src == 32'h0);
        ccr_next[`CDFA_CC_V] = 1'b0;
      end
      `CDFA_OP_PUSH, `CDFA_OP_POP:
        bad = (size_in == `CDFA_SZ_BYTE);
      `CDFA_OP_PSYNC_LD, `CDFA_OP_PSYNC_ST:
        bad = 1'b1;
      `CDFA_OP_ADD, `CDFA_OP_SUB, `CDFA_OP_ADD_WITH_CARRY, `CDFA_OP_SUB_WITH_BORROW,
      `CDFA_OP_CMP, `CDFA_OP_NEG: begin
        sub = (op_in != `CDFA_OP_ADD) && (op_in != `CDFA_OP_ADD_WITH_CARRY);
        a = (op_in == `CDFA_OP_NEG) ? 32'h0 : dst;
        b = (op_in == `CDFA_OP_NEG) ? dst : src;
        c0 = (op_in == `CDFA_OP_ADD_WITH_CARRY || op_in == `CDFA_OP_SUB_WITH_BORROW)
             ? cin : 1'b0;
        if ((op_in == `CDFA_OP_SUB && use_imm_in &&
             size_in == `CDFA_SZ_BYTE) ||
            ((op_in == `CDFA_OP_ADD_WITH_CARRY || op_in == `CDFA_OP_SUB_WITH_BORROW) &&
             size_in != `CDFA_SZ_BYTE))
          bad = 1'b1;
        if (sub)
          sum = {1'b0, a} - {1'b0, b} - {32'h0, c0};
        else
          sum = {1'b0, a} + {1'b0, b} + {32'h0, c0};
        res = fit(sum[31:0], size_in);
        wr_en = (op_in != `CDFA_OP_CMP);
        unique case (size_in)
          `CDFA_SZ_BYTE: begin
            hc = a[4] ^ b[4] ^ sum[4];
            ccr_next[`CDFA_CC_C] = a[8] ^ b[8] ^ sum[8];
          end
          `CDFA_SZ_WORD: begin
            hc = a[12] ^ b[12] ^ sum[12];
            ccr_next[`CDFA_CC_C] = a[16] ^ b[16] ^ sum[16];
          end
          default: begin
            hc = a[28] ^ b[28] ^ sum[28];
            ccr_next[`CDFA_CC_C] = sum[32];
          end
        endcase
        ccr_next[`CDFA_CC_H] = hc;
        ccr_next[`CDFA_CC_N] = msb(res, size_in);
        ccr_next[`CDFA_CC_Z] = (res == 32'h0);
        ccr_next[`CDFA_CC_V] = sub
          ? (msb(a, size_in) != msb(b, size_in)) &&
            (msb(res, size_in) != msb(a, size_in))
          : (msb(a, size_in) == msb(b, size_in)) &&
            (msb(res, size_in) != msb(a, size_in));
      end
      `CDFA_OP_INC, `CDFA_OP_DEC: begin
        // bit 1 of the immediate selects a step of 2
        bad = imm_in[1] && size_in == `CDFA_SZ_BYTE;
        res = fit((op_in == `CDFA_OP_INC)
              ? dst + (imm_in[1] ? 32'h2 : 32'h1)
              : dst - (imm_in[1] ? 32'h2 : 32'h1), size_in);
        wr_en = 1'b1;
        ccr_next[`CDFA_CC_N] = msb(res, size_in);
        ccr_next[`CDFA_CC_Z] = (res == 32'h0);
      end
      `CDFA_OP_ADDS, `CDFA_OP_ADDR_SUB_SMALL: begin
        bad = !(imm_in == 32'h1 || imm_in == 32'h2 ||
                imm_in == 32'h4);
        res = (op_in == `CDFA_OP_ADDS) ? gr_reg[rd_in] + imm_in
                                       : gr_reg[rd_in] - imm_in;
        wr_en = 1'b1;
      end
      `CDFA_OP_DAA, `CDFA_OP_DAS: begin
        lo = dst[3:0];
        hi = dst[7:4];
        adj = 8'h00;
        if (ccr_reg[`CDFA_CC_H] || lo > 4'h9)
          adj[3:0] = 4'h6;
        if (ccr_reg[`CDFA_CC_C] || dst[7:0] > 8'h99 ||
            (op_in == `CDFA_OP_DAA && hi > 4'h9))
          adj[7:4] = 4'h6;
        res = {24'h000000, (op_in == `CDFA_OP_DAA)
               ? dst[7:0] + adj : dst[7:0] - adj};
        wr_en = 1'b1;
        ccr_next[`CDFA_CC_C] = ccr_reg[`CDFA_CC_C] | (adj[7:4] != 4'h0);
        ccr_next[`CDFA_CC_N] = res[7];
        ccr_next[`CDFA_CC_Z] = (res[7:0] == 8'h00);
      end
      `CDFA_OP_MULU, `CDFA_OP_MULS: begin
        bad = (size_in == `CDFA_SZ_LONG);
        res = prod;
        wr_en = 1'b1;
      end
      `CDFA_OP_BITSET, `CDFA_OP_BITCLR, `CDFA_OP_BITTST: begin
        res = dst;
        res[bit_in] = (op_in == `CDFA_OP_BITSET);
        wr_en = (op_in != `CDFA_OP_BITTST);
        ccr_next[`CDFA_CC_Z] = !dst[bit_in];
      end
      default: ;
    endcase
    if (bad)
      ccr_next = ccr_reg;
  end

  // write-back: byte to its half, word to low half, mul double width
  task automatic wb(input logic [2:0] r, input logic [31:0] v,
                    input logic [1:0] sz, input logic hi, input logic m);
    if (m)
      gr_reg[r] <= (sz == `CDFA_SZ_BYTE)
                   ? {gr_reg[r][31:16], v[15:0]} : v;
    else if (sz == `CDFA_SZ_BYTE && hi)
      gr_reg[r][15:8] <= v[7:0];
    else if (sz == `CDFA_SZ_BYTE)
      gr_reg[r][7:0] <= v[7:0];
    else if (sz == `CDFA_SZ_WORD)
      gr_reg[r][15:0] <= v[15:0];
    else
      gr_reg[r] <= v;
  endtask : wb

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 8; i++)
        gr_reg[i] <= 32'h0;
    end else if (st_reg == cdfa_pkg::CDFA_IDLE && start_in && !bad) begin
      if (op_in == `CDFA_OP_PUSH)
        gr_reg[`CDFA_SP_IDX] <= sp_val -
          ((size_in == `CDFA_SZ_LONG) ? 32'h4 : 32'h2);
      else if (op_in == `CDFA_OP_POP)
        gr_reg[`CDFA_SP_IDX] <= sp_val +
          ((size_in == `CDFA_SZ_LONG) ? 32'h4 : 32'h2);
      else if (wr_en)
        wb(rd_in, res, (op_in == `CDFA_OP_ADDS || op_in == `CDFA_OP_ADDR_SUB_SMALL)
           ? `CDFA_SZ_LONG : size_in, hi_byte_in,
           op_in == `CDFA_OP_MULU || op_in == `CDFA_OP_MULS);
    end else if (st_reg == cdfa_pkg::CDFA_MEM && mem_ack_in && ld_reg) begin
      wb(dst_reg, fit(mem_rdata_in, sz_reg), sz_reg, 1'b0, 1'b0);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      ccr_reg <= `CDFA_CC_RESET;
    else if (st_reg == cdfa_pkg::CDFA_IDLE && start_in)
      ccr_reg <= ccr_next;
  end

  // sequencer and memory port
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= cdfa_pkg::CDFA_IDLE;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      group_out <= 3'h0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_size_out <= 2'h0;
      mem_addr_out <= 24'h0;
      mem_wdata_out <= 32'h0;
      dst_reg <= 3'h0;
      sz_reg <= 2'h0;
      ld_reg <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (st_reg)
        cdfa_pkg::CDFA_IDLE: if (start_in) begin
          group_out <= grp(op_in);
          illegal_out <= bad;
          dst_reg <= rd_in;
          sz_reg <= size_in;
          mem_size_out <= size_in;
          if (!bad && (op_in == `CDFA_OP_MOV_LOAD ||
              op_in == `CDFA_OP_MOV_STORE || op_in == `CDFA_OP_PUSH ||
              op_in == `CDFA_OP_POP)) begin
            ld_reg <= (op_in == `CDFA_OP_MOV_LOAD || op_in == `CDFA_OP_POP);
            mem_we_out <= (op_in == `CDFA_OP_MOV_STORE ||
                           op_in == `CDFA_OP_PUSH);
            // word and long accesses ignore address bit 0
            if (op_in == `CDFA_OP_PUSH)
              mem_addr_out <= {sp_val[23:1] - ((size_in == `CDFA_SZ_LONG)
                               ? 23'h2 : 23'h1), 1'b0};
            else if (op_in == `CDFA_OP_POP)
              mem_addr_out <= {sp_val[23:1], 1'b0};
            else
              mem_addr_out <= {imm_in[23:1], imm_in[0] &&
                               size_in == `CDFA_SZ_BYTE};
            mem_wdata_out <= fit(gr_reg[(op_in == `CDFA_OP_PUSH ||
              op_in == `CDFA_OP_MOV_STORE) ? rd_in : rs_in], size_in);
            mem_req_out <= 1'b1;
            busy_out <= 1'b1;
            st_reg <= cdfa_pkg::CDFA_MEM;
          end else begin
            done_out <= 1'b1;
          end
        end
        cdfa_pkg::CDFA_MEM: if (mem_ack_in) begin
          mem_req_out <= 1'b0;
          mem_we_out <= 1'b0;
          st_reg <= cdfa_pkg::CDFA_DONE;
        end
        cdfa_pkg::CDFA_DONE: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          st_reg <= cdfa_pkg::CDFA_IDLE;
        end
        default: st_reg <= cdfa_pkg::CDFA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      fetch_addr_out <= 24'h0;
    else
      fetch_addr_out <= {fetch_pc_in[23:1], 1'b0};
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ccr_out <= `CDFA_CC_RESET;
      rd_value_out <= 32'h0;
    end else begin
      ccr_out <= ccr_reg;
      rd_value_out <= gr_reg[rd_in];
    end
  end
endmodule : cdfa_core

// ---- design/cdfa_regs.svh ----
`ifndef CDFA_REGS_SVH
`define CDFA_REGS_SVH
// operation codes presented on op_in
`define CDFA_OP_MOV_RR     6'h00
`define CDFA_OP_MOV_IMM    6'h01
`define CDFA_OP_MOV_LOAD   6'h02
`define CDFA_OP_MOV_STORE  6'h03
`define CDFA_OP_POP        6'h04
`define CDFA_OP_PUSH       6'h05
`define CDFA_OP_PSYNC_LD   6'h06
`define CDFA_OP_PSYNC_ST   6'h07
`define CDFA_OP_ADD        6'h08
`define CDFA_OP_SUB        6'h09
`define CDFA_OP_ADD_WITH_CARRY       6'h0a
`define CDFA_OP_SUB_WITH_BORROW       6'h0b
`define CDFA_OP_INC        6'h0c
`define CDFA_OP_DEC        6'h0d
`define CDFA_OP_ADDS       6'h0e
`define CDFA_OP_ADDR_SUB_SMALL       6'h0f
`define CDFA_OP_DAA        6'h10
`define CDFA_OP_DAS        6'h11
`define CDFA_OP_MULU       6'h12
`define CDFA_OP_MULS       6'h13
`define CDFA_OP_CMP        6'h14
`define CDFA_OP_NEG        6'h15
`define CDFA_OP_BITSET     6'h16
`define CDFA_OP_BITCLR     6'h17
`define CDFA_OP_BITTST     6'h18
// number of instruction types of the full set; the decoder knows only 25 op codes
`define CDFA_NUM_TYPES     62
// operand sizes on size_in
`define CDFA_SZ_BYTE       2'h0
`define CDFA_SZ_WORD       2'h1
`define CDFA_SZ_LONG       2'h2
// flag positions in the condition code register
`define CDFA_CC_I          7
`define CDFA_CC_H          5
`define CDFA_CC_N          3
`define CDFA_CC_Z          2
`define CDFA_CC_V          1
`define CDFA_CC_C          0
`define CDFA_CC_RESET      8'h80
// stack pointer register index
`define CDFA_SP_IDX        3'h7
`endif

// ---- design/cdfa_pkg.sv ----
package cdfa_pkg;
  typedef enum logic [1:0] {
    CDFA_IDLE = 2'b00,
    CDFA_MEM  = 2'b01,
    CDFA_DONE = 2'b11
  } cdfa_state_t;
  typedef enum logic [2:0] {
    CDFA_GRP_XFER  = 3'h0,
    CDFA_GRP_ARITH = 3'h1,
    CDFA_GRP_LOGIC = 3'h2,
    CDFA_GRP_SHIFT = 3'h3,
    CDFA_GRP_BIT   = 3'h4,
    CDFA_GRP_BRAN  = 3'h5,
    CDFA_GRP_SYS   = 3'h6,
    CDFA_GRP_BLOCK = 3'h7
  } cdfa_group_t;
endpackage : cdfa_pkg

// ---- design/cdfa_mul.sv ----
`timescale 1ns/10ps
`include "cdfa_regs.svh"
module cdfa_mul (
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] b_in,
  input  wire logic        word_in,
  input  wire logic        signed_in,
  output logic      [31:0] prod_out
);
  logic signed [16:0] a_ext;
  logic signed [16:0] b_ext;
  logic signed [33:0] full;
  // one 17-bit signed multiplier serves all four forms
  always_comb begin
    if (word_in) begin
      a_ext = {signed_in & a_in[15], a_in};
      b_ext = {signed_in & b_in[15], b_in};
    end else begin
      a_ext = {{9{signed_in & a_in[7]}}, a_in[7:0]};
      b_ext = {{9{signed_in & b_in[7]}}, b_in[7:0]};
    end
    full = a_ext * b_ext;
    prod_out = word_in ? full[31:0] : {16'h0000, full[15:0]};
  end
endmodule : cdfa_mul

// ---- dv/cdfa_core_asserts.sv ----
`timescale 1ns/10ps
`include "cdfa_regs.svh"
module cdfa_core_asserts (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        start_in,
  input wire logic [5:0]  op_in,
  input wire logic [1:0]  size_in,
  input wire logic [31:0] imm_in,
  input wire logic        use_imm_in,
  input wire logic [23:0] fetch_pc_in,
  input wire logic        mem_ack_in,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        illegal_out,
  input wire logic [2:0]  group_out,
  input wire logic [23:0] fetch_addr_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [1:0]  mem_size_out,
  input wire logic [23:0] mem_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic go;
  assign go = start_in && !busy_out;
  chk_fetch_even:
    assert property (1'b1 |=> fetch_addr_out ==
      ($past(fetch_pc_in) & 24'hfffffe)) else $error("fetch not aligned");
  chk_mem_even:
    assert property (mem_req_out && mem_size_out != `CDFA_SZ_BYTE
      |-> !mem_addr_out[0]) else $error("odd bus address");
  chk_req_hold:
    assert property (mem_req_out && !mem_ack_in |=> mem_req_out &&
      $stable(mem_addr_out) && $stable(mem_we_out))
      else $error("request not held");
  chk_ack_done:
    assert property (mem_req_out && mem_ack_in |=> !mem_req_out ##[1:2]
      done_out) else $error("no done after ack");
  chk_start_ans:
    assert property (go |-> ##[1:2] (done_out || mem_req_out))
      else $error("start not answered");
  chk_psync_off:
    assert property (go && (op_in == `CDFA_OP_PSYNC_LD ||
      op_in == `CDFA_OP_PSYNC_ST) |-> ##[1:2] (done_out && illegal_out
      && !mem_req_out)) else $error("sync transfer accepted");
  chk_subimm_byte:
    assert property (go && op_in == `CDFA_OP_SUB && use_imm_in &&
      size_in == `CDFA_SZ_BYTE |-> ##[1:2] (done_out && illegal_out))
      else $error("byte immediate sub accepted");
  chk_carry_byte:
    assert property (go && (op_in == `CDFA_OP_ADD_WITH_CARRY ||
      op_in == `CDFA_OP_SUB_WITH_BORROW) && size_in != `CDFA_SZ_BYTE
      |-> ##[1:2] (done_out && illegal_out)) else $error("wide carry op");
  chk_incdec_step:
    assert property (go && (op_in == `CDFA_OP_INC || op_in == `CDFA_OP_DEC)
      && size_in == `CDFA_SZ_BYTE && imm_in[1] |-> ##[1:2]
      (done_out && illegal_out)) else $error("byte step of two");
  chk_small_step:
    assert property (go && (op_in == `CDFA_OP_ADDS || op_in == `CDFA_OP_ADDR_SUB_SMALL)
      && !(imm_in inside {32'h1, 32'h2, 32'h4}) |-> ##[1:2]
      (done_out && illegal_out)) else $error("bad address step");
  chk_arith_group:
    assert property (go && op_in == `CDFA_OP_ADD |-> ##[1:2] (done_out &&
      !illegal_out && group_out == cdfa_pkg::CDFA_GRP_ARITH))
      else $error("add not classed arithmetic");
endmodule : cdfa_core_asserts
bind cdfa_core cdfa_core_asserts i_cdfa_core_asserts (.clk_in, .rst_in,
  .start_in, .op_in, .size_in, .imm_in, .use_imm_in, .fetch_pc_in,
  .mem_ack_in, .busy_out, .done_out, .illegal_out, .group_out,
  .fetch_addr_out, .mem_req_out, .mem_we_out, .mem_size_out, .mem_addr_out);

// ---- dv/cdfa_mem_model.sv ----
`timescale 1ns/10ps
module cdfa_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [23:0] mem_addr_in,
  input  wire logic [31:0] mem_wdata_in,
  output logic             mem_ack_out,
  output logic      [31:0] mem_rdata_out
);
  // one entry per value of address bits 7:0: lane order stays the core's business
  logic [31:0] mem_reg [256];
  logic [3:0]  cnt_reg;
  initial foreach (mem_reg[i]) mem_reg[i] = 32'h0;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 4'h0;
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 32'h0;
    end else if (mem_ack_out) begin
      // released bus shows the inverse, never the stale word
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
    end else if (mem_req_in && cnt_reg == wait_in) begin
      cnt_reg <= 4'h0;
      mem_ack_out <= 1'b1;
      if (mem_we_in)
        mem_reg[mem_addr_in[7:0]] <= mem_wdata_in;
      else
        mem_rdata_out <= mem_reg[mem_addr_in[7:0]];
    end else if (mem_req_in) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : cdfa_mem_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`include "cdfa_regs.svh"
module testbench;
  logic        clk_in, rst_in, start_in, use_imm_in, hi_byte_in;
  logic        busy_out, done_out, illegal_out, mem_req_out, mem_we_out;
  logic        mem_ack_in, cap_we, seen;
  logic [5:0]  op_in;
  logic [1:0]  size_in, mem_size_out;
  logic [2:0]  rd_in, rs_in, bit_in, group_out;
  logic [31:0] imm_in, mem_rdata_in, mem_wdata_out, rd_value_out;
  logic [23:0] fetch_pc_in, fetch_addr_out, mem_addr_out, cap_addr;
  logic [7:0]  ccr_out;
  logic [3:0]  wait_cy;
  int          err_total, compares;
  localparam logic [1:0] sz_b = `CDFA_SZ_BYTE;
  localparam logic [1:0] sz_w = `CDFA_SZ_WORD;
  localparam logic [1:0] sz_l = `CDFA_SZ_LONG;
  cdfa_core i_cdfa_core (.clk_in, .rst_in, .start_in, .op_in, .size_in,
    .rd_in, .rs_in, .imm_in, .use_imm_in, .hi_byte_in, .bit_in,
    .fetch_pc_in, .mem_rdata_in, .mem_ack_in, .busy_out, .done_out,
    .illegal_out, .group_out, .fetch_addr_out, .mem_req_out, .mem_we_out,
    .mem_size_out, .mem_addr_out, .mem_wdata_out, .ccr_out, .rd_value_out);
  cdfa_mem_model i_cdfa_mem_model (.clk_in, .rst_in, .wait_in(wait_cy),
    .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic bad(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : bad
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
      bad($sformatf("value %h expected %h", g, e));
  endtask : chk_val
  task automatic chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e)
      bad($sformatf("flag %b expected %b", g, e));
  endtask : chk_bit
  // start one operation and wait, bounded, for its done pulse
  task automatic op(input logic [5:0] o, input logic [1:0] s,
    input logic [2:0] d, input logic [2:0] r, input logic [31:0] im,
    input logic u);
    int n;
    @(negedge clk_in);
    {op_in, size_in, rd_in, rs_in, imm_in, use_imm_in} = {o, s, d, r, im, u};
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    seen = 1'b0;
    for (n = 0; n < 60 && done_out !== 1'b1; n++) begin
      if (mem_req_out === 1'b1)
        {seen, cap_addr, cap_we} = {1'b1, mem_addr_out, mem_we_out};
      @(negedge clk_in);
    end
    if (n == 60)
      bad("operation never finished");
    if (n == 60)
      give_verdict();
  endtask : op
  task automatic ld(input logic [2:0] r, input logic [31:0] v);
    op(`CDFA_OP_MOV_IMM, sz_l, r, 3'h0, v, 1'b1);
  endtask : ld
  task automatic rd_chk(input logic [2:0] r, input logic [31:0] e);
    @(negedge clk_in);
    rd_in = r;
    @(negedge clk_in);
    chk_val(rd_value_out, e);
  endtask : rd_chk
  task automatic s_fetch();
    @(negedge clk_in);
    fetch_pc_in = 24'h000123;
    repeat (2) @(negedge clk_in);
    chk_val({8'h0, fetch_addr_out}, 32'h122);
  endtask : s_fetch
  task automatic s_add();
    logic [31:0] a [3];
    a = '{32'hf, 32'hfff, 32'hfffffff};
    for (int i = 0; i < 3; i++) begin
      ld(3'h0, a[i]);
      ld(3'h1, 32'h1);
      op(`CDFA_OP_ADD, 2'(i), 3'h0, 3'h1, 32'h0, 1'b0);
      rd_chk(3'h0, a[i] + 32'h1);
      chk_bit(ccr_out[`CDFA_CC_H], 1'b1);
    end
    chk_val({29'h0, group_out}, 32'h1);
    ld(3'h2, 32'h55);
    op(`CDFA_OP_SUB, sz_b, 3'h2, 3'h0, 32'h1, 1'b1);
    chk_bit(illegal_out, 1'b1);
    op(`CDFA_OP_SUB, sz_w, 3'h2, 3'h0, 32'h5, 1'b1);
    rd_chk(3'h2, 32'h50);
  endtask : s_add
  task automatic s_carry();
    ld(3'h3, 32'hff);
    ld(3'h4, 32'h1);
    op(`CDFA_OP_ADD, sz_b, 3'h3, 3'h4, 32'h0, 1'b0);
    rd_chk(3'h3, 32'h0);
    chk_bit(ccr_out[`CDFA_CC_C], 1'b1);
    op(`CDFA_OP_ADD_WITH_CARRY, sz_b, 3'h3, 3'h0, 32'h5, 1'b1);
    rd_chk(3'h3, 32'h6);
    op(`CDFA_OP_SUB_WITH_BORROW, sz_w, 3'h3, 3'h0, 32'h1, 1'b1);
    chk_bit(illegal_out, 1'b1);
    op(`CDFA_OP_MOV_RR, sz_w, 3'h5, 3'h4, 32'h0, 1'b0);
    rd_chk(3'h5, 32'h1);
    op(`CDFA_OP_NEG, sz_b, 3'h5, 3'h0, 32'h0, 1'b0);
    rd_chk(3'h5, 32'hff);
    chk_bit(ccr_out[`CDFA_CC_H], 1'b1);
    op(`CDFA_OP_CMP, sz_b, 3'h5, 3'h0, 32'hff, 1'b1);
    rd_chk(3'h5, 32'hff);
    chk_bit(ccr_out[`CDFA_CC_H], 1'b0);
    chk_bit(ccr_out[`CDFA_CC_Z], 1'b1);
  endtask : s_carry
  task automatic s_step();
    ld(3'h5, 32'h10);
    op(`CDFA_OP_INC, sz_w, 3'h5, 3'h0, 32'h2, 1'b0);
    rd_chk(3'h5, 32'h12);
    op(`CDFA_OP_INC, sz_b, 3'h5, 3'h0, 32'h2, 1'b0);
    chk_bit(illegal_out, 1'b1);
    op(`CDFA_OP_DEC, sz_b, 3'h5, 3'h0, 32'h0, 1'b0);
    rd_chk(3'h5, 32'h11);
    ld(3'h6, 32'hfffffff9);
    for (int i = 0; i < 3; i++)
      op(`CDFA_OP_ADDS, sz_l, 3'h6, 3'h0, 32'h1 << i, 1'b1);
    rd_chk(3'h6, 32'h0);
    op(`CDFA_OP_ADDR_SUB_SMALL, sz_l, 3'h6, 3'h0, 32'h4, 1'b1);
    op(`CDFA_OP_ADDR_SUB_SMALL, sz_l, 3'h6, 3'h0, 32'h3, 1'b1);
    chk_bit(illegal_out, 1'b1);
    rd_chk(3'h6, 32'hfffffffc);
  endtask : s_step
  task automatic s_decimal();
    ld(3'h0, 32'h9);
    ld(3'h1, 32'h1);
    op(`CDFA_OP_ADD, sz_b, 3'h0, 3'h1, 32'h0, 1'b0);
    rd_chk(3'h0, 32'ha);
    op(`CDFA_OP_DAA, sz_b, 3'h0, 3'h0, 32'h0, 1'b0);
    rd_chk(3'h0, 32'h10);
    op(`CDFA_OP_SUB, sz_b, 3'h0, 3'h1, 32'h0, 1'b0);
    rd_chk(3'h0, 32'hf);
    op(`CDFA_OP_DAS, sz_b, 3'h0, 3'h0, 32'h0, 1'b0);
    rd_chk(3'h0, 32'h9);
  endtask : s_decimal
  task automatic s_mul();
    logic [5:0]  o [4];
    logic [31:0] a [4];
    logic [31:0] e [4];
    o = '{`CDFA_OP_MULU, `CDFA_OP_MULS, `CDFA_OP_MULU, `CDFA_OP_MULS};
    a = '{32'hff, 32'hff, 32'hffff, 32'hffff};
    e = '{32'hfe01, 32'h1, 32'h1fffe, 32'hfffffffe};
    for (int i = 0; i < 4; i++) begin
      ld(3'h2, a[i]);
      ld(3'h3, i < 2 ? a[i] : 32'h2);
      op(o[i], i < 2 ? sz_b : sz_w, 3'h2, 3'h3, 32'h0, 1'b0);
      rd_chk(3'h2, e[i]);
    end
    op(`CDFA_OP_MULU, sz_l, 3'h2, 3'h3, 32'h0, 1'b0);
    chk_bit(illegal_out, 1'b1);
  endtask : s_mul
  task automatic s_bits();
    ld(3'h4, 32'h0);
    hi_byte_in = 1'b1;
    for (int b = 0; b < 8; b++) begin
      bit_in = 3'(b);
      op(`CDFA_OP_BITSET, sz_b, 3'h4, 3'h0, 32'h0, 1'b0);
    end
    op(`CDFA_OP_BITCLR, sz_b, 3'h4, 3'h0, 32'h0, 1'b0);
    hi_byte_in = 1'b0;
    rd_chk(3'h4, 32'h7f00);
    chk_val({29'h0, group_out}, 32'h4);
  endtask : s_bits
  task automatic s_mem();
    wait_cy = 4'h5;
    ld(3'h3, 32'h12345678);
    op(`CDFA_OP_MOV_STORE, sz_l, 3'h3, 3'h0, 32'h41, 1'b0);
    chk_val({7'h0, cap_we, cap_addr}, 32'h1000040);
    chk_val({30'h0, mem_size_out}, {30'h0, sz_l});
    chk_val(mem_wdata_out, 32'h12345678);
    chk_bit(busy_out, 1'b0);
    op(`CDFA_OP_MOV_LOAD, sz_l, 3'h4, 3'h0, 32'h41, 1'b0);
    rd_chk(3'h4, 32'h12345678);
    wait_cy = 4'h0;
  endtask : s_mem
  task automatic s_stack();
    ld(3'h7, 32'h100);
    ld(3'h5, 32'hbeef);
    ld(3'h6, 32'h0);
    // word and long sizes only through the stack pointer
    op(`CDFA_OP_PUSH, sz_w, 3'h5, 3'h0, 32'h0, 1'b0);
    chk_val({7'h0, cap_we, cap_addr}, 32'h10000fe);
    rd_chk(3'h7, 32'hfe);
    op(`CDFA_OP_POP, sz_w, 3'h6, 3'h0, 32'h0, 1'b0);
    rd_chk(3'h6, 32'hbeef);
    rd_chk(3'h7, 32'h100);
    op(`CDFA_OP_PUSH, sz_b, 3'h5, 3'h0, 32'h0, 1'b0);
    chk_bit(illegal_out, 1'b1);
    op(`CDFA_OP_PSYNC_LD, sz_b, 3'h5, 3'h0, 32'h40, 1'b0);
    chk_bit(illegal_out & ~seen, 1'b1);
    op(`CDFA_OP_PSYNC_ST, sz_b, 3'h5, 3'h0, 32'h40, 1'b0);
    chk_bit(illegal_out & ~seen, 1'b1);
  endtask : s_stack
  initial begin
    {err_total, compares} = {32'h0, 32'h0};
    {rst_in, start_in, use_imm_in, hi_byte_in} = 4'h8;
    {op_in, size_in, rd_in, rs_in, bit_in, imm_in} = 49'h0;
    {fetch_pc_in, wait_cy} = 28'h0;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    s_fetch();
    s_add();
    s_carry();
    s_step();
    s_decimal();
    s_mul();
    s_bits();
    s_mem();
    s_stack();
    give_verdict();
  end
endmodule : testbench
